// ---- logic/sequence_input_allocator_defines.svh ----
// Register map, field positions, reset values and codes of the input allocator
//
// Summary of operation
// - Selection word is 16 bits: mode, servo-on, proportional, forward-limit digits; reset 1881.
// - A zero written into the mode digit is stored as one.
// - Servo-on and proportional-control digits always store 8, whatever is written.
// - Codes 0-6 pick an input, limit on while low; 7 forces on, 8 off.
// - Codes 9-F pick the same inputs in order, limit on while input high.
`ifndef SEQUENCE_INPUT_ALLOCATOR_DEFINES_SVH
`define SEQUENCE_INPUT_ALLOCATOR_DEFINES_SVH

// Byte addresses on the register bus
`define SEL_WORD_ADDR 12'h000
`define STATUS_ADDR 12'h004
`define DECODE_WIDTH 12

// Selection word layout
`define SEL_WORD_WIDTH 16
`define SEL_WORD_RESET 16'h1881
`define MODE_LSB 0
`define SERVO_ON_LSB 4
`define PROP_CTRL_LSB 8
`define FWD_LIMIT_LSB 12
`define DIGIT_WIDTH 4

// Corrected digit values
`define MODE_ILLEGAL 4'h0
`define MODE_MAPPED 4'h1
`define MAPPING_FIXED 4'h8

// Forward-limit mapping codes
`define FWD_LOW_LAST 4'h6
`define FWD_FORCE_ON 4'h7
`define FWD_FORCE_OFF 4'h8
`define FWD_HIGH_FIRST 4'h9

// Status word layout
`define STATUS_LIMIT_BIT 8

// Connector inputs idle high (switch open, signal off)
`define INPUT_IDLE 1'b1

`endif

// ---- logic/sequence_input_allocator_pkg.sv ----
// Types shared by the input allocator
`default_nettype none
package sequence_input_allocator_pkg;

  // How the forward-limit signal is derived from the selected input
  typedef enum logic [1:0] {
    sense_on_low = 2'h0,
    sense_force_on = 2'h1,
    sense_force_off = 2'h3,
    sense_on_high = 2'h2
  } limit_sense_t;

  // Register selected by a bus address phase
  typedef enum logic [1:0] {
    reg_none = 2'h0,
    reg_sel_word = 2'h1,
    reg_status = 2'h3
  } reg_sel_t;

endpackage
`default_nettype wire

// ---- logic/sequence_input_allocator.sv ----
// Input allocator: maps a connector input onto the forward-travel-limit signal
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sequence_input_allocator_defines.svh"

module sequence_input_allocator #(
  parameter int NUM_INPUTS = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NUM_INPUTS-1:0] io_connector_n,
  output logic forward_travel_limit,
  output logic [`SEL_WORD_WIDTH-1:0] input_allocation_select_1
);

  // The code table names exactly seven inputs; other counts have no meaning
  if (NUM_INPUTS != 7) begin : g_bad_inputs
    $error("sequence_input_allocator: NUM_INPUTS must be 7");
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [NUM_INPUTS-1:0] sync_meta;
  logic [NUM_INPUTS-1:0] sync_pin;

  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync_meta[i] <= `INPUT_IDLE;
        sync_pin[i] <= `INPUT_IDLE;
      end else begin
        sync_meta[i] <= io_connector_n[i];
        sync_pin[i] <= sync_meta[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus address phase decode
  // ---------------------------------------------------------------
  wire logic bus_take;
  wire logic [`DECODE_WIDTH-1:0] bus_addr;
  wire sequence_input_allocator_pkg::reg_sel_t bus_reg;

  // Only NONSEQ/SEQ with the bus ready start a transfer
  assign bus_take = hsel && htrans[1] && hready;
  assign bus_addr = haddr[`DECODE_WIDTH-1:0];
  assign bus_reg = (bus_addr == `SEL_WORD_ADDR) ? sequence_input_allocator_pkg::reg_sel_word :
                   (bus_addr == `STATUS_ADDR) ? sequence_input_allocator_pkg::reg_status :
                   sequence_input_allocator_pkg::reg_none;

  // Write data arrives one cycle after its address phase
  logic wr_pending;
  wire logic wr_take;

  assign wr_take = bus_take && hwrite && (bus_reg == sequence_input_allocator_pkg::reg_sel_word);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
    end else begin
      wr_pending <= wr_take;
    end
  end

  // ---------------------------------------------------------------
  // Selection word with self-correcting digits
  // ---------------------------------------------------------------
  logic [`SEL_WORD_WIDTH-1:0] sel_word;
  wire logic [`DIGIT_WIDTH-1:0] wr_mode;
  wire logic [`DIGIT_WIDTH-1:0] wr_fwd;
  wire logic [`DIGIT_WIDTH-1:0] fixed_mode;
  wire logic [`SEL_WORD_WIDTH-1:0] corrected_word;
  wire logic [`SEL_WORD_WIDTH-1:0] next_sel_word;

  assign wr_mode = hwdata[`MODE_LSB +: `DIGIT_WIDTH];
  assign wr_fwd = hwdata[`FWD_LIMIT_LSB +: `DIGIT_WIDTH];
  assign fixed_mode = (wr_mode == `MODE_ILLEGAL) ? `MODE_MAPPED : wr_mode;
  // Servo-on and proportional digits are not settable at all
  assign corrected_word = {wr_fwd, `MAPPING_FIXED, `MAPPING_FIXED, fixed_mode};
  assign next_sel_word = wr_pending ? corrected_word : sel_word;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_word <= `SEL_WORD_RESET;
    end else begin
      sel_word <= next_sel_word;
    end
  end

  // ---------------------------------------------------------------
  // Forward-limit mapping
  // ---------------------------------------------------------------
  wire logic [`DIGIT_WIDTH-1:0] fwd_code;
  wire sequence_input_allocator_pkg::limit_sense_t fwd_sense;
  wire logic [`DIGIT_WIDTH-1:0] high_offset;
  wire logic [2:0] pin_index;
  wire logic sense_pin;
  wire logic [NUM_INPUTS-1:0] pin_pick;
  wire logic pin_level;
  wire logic limit_low;
  wire logic limit_high;
  wire logic limit_forced;
  wire logic next_limit;

  // Codes 0..6 sense low, 7 and 8 force, 9..F sense high
  assign fwd_code = sel_word[`FWD_LIMIT_LSB +: `DIGIT_WIDTH];
  assign fwd_sense = (fwd_code <= `FWD_LOW_LAST) ? sequence_input_allocator_pkg::sense_on_low :
                     (fwd_code == `FWD_FORCE_ON) ? sequence_input_allocator_pkg::sense_force_on :
                     (fwd_code == `FWD_FORCE_OFF) ? sequence_input_allocator_pkg::sense_force_off :
                     sequence_input_allocator_pkg::sense_on_high;
  // Codes 9..F reuse the input order of codes 0..6
  assign high_offset = fwd_code - `FWD_HIGH_FIRST;
  assign pin_index = (fwd_code <= `FWD_LOW_LAST) ? fwd_code[2:0] : high_offset[2:0];

  // Only the two sensing classes look at an input at all
  assign sense_pin = (fwd_sense == sequence_input_allocator_pkg::sense_on_low) ||
                     (fwd_sense == sequence_input_allocator_pkg::sense_on_high);

  // One-hot pick: force codes select nothing, so no index runs past the bank
  for (genvar k = 0; k < NUM_INPUTS; k++) begin : g_pick
    assign pin_pick[k] = sense_pin && (pin_index == 3'(k)) && sync_pin[k];
  end
  assign pin_level = |pin_pick;

  // A closed switch pulls its input low
  assign limit_low = !pin_level;
  assign limit_high = pin_level;
  assign limit_forced = (fwd_sense == sequence_input_allocator_pkg::sense_force_on);
  assign next_limit = (fwd_sense == sequence_input_allocator_pkg::sense_on_low) ? limit_low :
                      (fwd_sense == sequence_input_allocator_pkg::sense_on_high) ? limit_high :
                      limit_forced;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      forward_travel_limit <= 1'b0;
    end else begin
      forward_travel_limit <= next_limit;
    end
  end

  // ---------------------------------------------------------------
  // Read data and response
  // ---------------------------------------------------------------
  wire logic rd_take;
  wire logic hit_sel_word;
  wire logic hit_status;
  wire logic [31:0] status_word;
  wire logic [31:0] read_value;
  wire logic [31:0] next_hrdata;

  assign rd_take = bus_take && !hwrite;
  assign hit_sel_word = (bus_reg == sequence_input_allocator_pkg::reg_sel_word);
  assign hit_status = (bus_reg == sequence_input_allocator_pkg::reg_status);

  // Synchronised pins low, limit above a spare bit; status takes no writes
  assign status_word = {23'h000000, forward_travel_limit, 1'b0, sync_pin};
  // Bypass the pending write so a read right behind a write sees new data
  // Unmapped addresses read as zero
  assign read_value = hit_sel_word ? {16'h0000, next_sel_word} :
                      hit_status ? status_word :
                      32'h00000000;
  // Read data returns to zero outside a read's data phase
  assign next_hrdata = rd_take ? read_value : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // Zero wait states: the slave never stalls a transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // No error response is ever given, whatever the address or size
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Mirror of the stored word for the sequence logic
  // Loaded from the next value so it changes in the same cycle as the word itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_allocation_select_1 <= `SEL_WORD_RESET;
    end else begin
      input_allocation_select_1 <= next_sel_word;
    end
  end

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The four digits must fill the selection word exactly
  if (4 * `DIGIT_WIDTH != `SEL_WORD_WIDTH) begin : g_bad_word
    $error("sequence_input_allocator: digit layout does not fill the word");
  end

endmodule
`default_nettype wire

// ---- bench/sequence_input_allocator_properties.sv ----
// Checker of the allocator selection word and limit mapping
`timescale 1ns/10ps
`default_nettype none
module allocator_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [6:0] io_connector_n,
  input wire logic forward_travel_limit,
  input wire logic [15:0] input_allocation_select_1
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [2:0] up;
  logic [6:0] p1, p2, p3;
  logic [3:0] s1;
  wire ok = up == 3'h4;
  // Pipes stay unreset; only trusted once four edges clear of reset
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) up <= 3'h0;
    else if (!ok) up <= up + 3'h1;
  always_ff @(posedge hclk) begin
    p1 <= io_connector_n;
    p2 <= p1;
    p3 <= p2;
    s1 <= input_allocation_select_1[15:12];
  end
  a_reset_word: assert property (up == 3'h1 |-> input_allocation_select_1 == 16'h1881)
    else $error("selection word not at factory value");
  a_mode_digit: assert property (input_allocation_select_1[3:0] != 4'h0)
    else $error("mode digit holds zero");
  a_fixed_digits: assert property (input_allocation_select_1[11:4] == 8'h88)
    else $error("fixed digits not 8");
  a_low_sense: assert property (ok && s1 < 4'h7 |-> forward_travel_limit == !p3[s1[2:0]])
    else $error("limit wrong for low sense");
  a_forced_level: assert property (ok && (s1 == 4'h7 || s1 == 4'h8)
    |-> forward_travel_limit == (s1 == 4'h7)) else $error("forced limit wrong");
  a_high_sense: assert property (ok && s1 > 4'h8 |-> forward_travel_limit == p3[s1 - 4'h9])
    else $error("limit wrong for high sense");
  a_limit_settles: assert property ((ok && $stable(io_connector_n)
    && $stable(input_allocation_select_1)) [*4] |-> $stable(forward_travel_limit))
    else $error("limit moved with inputs still");
endmodule
bind sequence_input_allocator allocator_props allocator_props_inst (.hclk, .hresetn,
  .io_connector_n, .forward_travel_limit, .input_allocation_select_1);
`default_nettype wire

// ---- bench/switch_bank.sv ----
// External switches on the connector inputs
`timescale 1ns/10ps
`default_nettype none
module switch_bank (
  input wire logic clk,
  input wire logic [6:0] want,
  output logic [6:0] io_connector_n
);
  // Open switches idle high
  initial io_connector_n = 7'h7f;
  always @(posedge clk) io_connector_n <= want;
endmodule
`default_nettype wire

// ---- bench/sequence_input_allocator_tb.sv ----
// Bench: register access and limit mapping of the allocator
`timescale 1ns/10ps
`default_nettype none
module sequence_input_allocator_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic [6:0] want = 7'h7f, pins;
  logic hreadyout, hresp, limit;
  logic [15:0] sel;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  always #10 hclk = ~hclk;
  switch_bank switch_bank_inst (.clk(hclk), .want(want), .io_connector_n(pins));
  sequence_input_allocator sequence_input_allocator_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .io_connector_n(pins), .forward_travel_limit(limit),
    .input_allocation_select_1(sel));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Sampled mid-cycle: hrdata stands only for the data phase
  task automatic phase;
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      q = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    phase();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    phase();
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 32'h0, 32'h0);
    check(q, 32'h1881);
    xfer(1'b1, 32'h0, 32'h0);
    xfer(1'b0, 32'h0, 32'h0);
    check(q, 32'h0881);
    xfer(1'b1, 32'h0, 32'h5a72);
    xfer(1'b0, 32'h0, 32'h0);
    check(q, 32'h5882);
    xfer(1'b0, 32'h8, 32'h0);
    check(q, 32'h0);
    for (int c = 0; c < 16; c++) begin
      xfer(1'b1, 32'h0, {16'h0, c[3:0], 12'h000});
      @(negedge hclk);
      check(sel, {16'h0, c[3:0], 12'h881});
      for (int i = 0; i < 7; i++) begin
        want <= c < 9 ? ~(7'h1 << i) : 7'h1 << i;
        repeat (6) @(posedge hclk);
        check(limit, c == 7 || (c < 7 && i == c) || (c > 8 && i == c - 9));
      end
    end
    xfer(1'b0, 32'h4, 32'h0);
    check(q, 32'h140);
    check(hresp, 32'h0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check(sel, 32'h1881);
    check(limit, 32'h0);
    hresetn <= 1'b1;
    xfer(1'b0, 32'h0, 32'h0);
    check(q, 32'h1881);
    close_out();
  end
endmodule
`default_nettype wire
